// ### lcv_pkg.sv
// constants, field layout and the zero-run threshold decode shared by the
// line code violation monitor files.
// assumes one register word per aligned 32-bit wishbone address.
package lcv_pkg;

    // ------------------------------------------------------------
    // line code selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {LC_AMI, LC_B8ZS, LC_HDB3} lcv_code_t;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_LINE_CFG = 8'h00;
    localparam logic [7:0] REG_FAULT_CTRL = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS_TWO = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK_TWO = 8'h0C;
    localparam logic [7:0] REG_PATH_STATE = 8'h10;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CFG_CODE_LSB = 0;
    localparam int CFG_E1_BIT = 2;
    localparam int CFG_SINGLE_RAIL_BIT = 3;
    localparam int LINE_ZERO_RUN_BIT = 2;
    localparam int SYS_ZERO_RUN_BIT = 3;
    localparam int LINE_VIOLATION_BIT = 4;
    localparam int SYS_VIOLATION_BIT = 5;
    localparam int INSERT_REQ_BIT = 6;
    localparam int ZERO_DEF_BIT = 7;

    // ------------------------------------------------------------
    // reset values and implemented bits
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h3C;
    localparam logic [7:0] STATUS_USED = 8'h3C;

    // ------------------------------------------------------------
    // zero-run thresholds and substitution gaps
    // ------------------------------------------------------------
    localparam logic [6:0] ZR_AMI_ANSI = 7'h0F;
    localparam logic [6:0] ZR_AMI_FCC_T1 = 7'h50;
    localparam logic [6:0] ZR_B8ZS = 7'h07;
    localparam logic [6:0] ZR_HDB3 = 7'h03;
    localparam logic [6:0] B8ZS_FIRST_GAP = 7'h03;
    localparam logic [6:0] B8ZS_SECOND_GAP = 7'h01;
    localparam logic [6:0] HDB3_LONG_GAP = 7'h03;
    localparam logic [6:0] HDB3_SHORT_GAP = 7'h02;

    // single rail nrz streams carry no coding, so they take AMI limits
    function automatic logic [6:0] lcv_zero_limit(input lcv_code_t code,
        input logic fcc, input logic e1, input logic singleRail);
        logic [6:0] lim;
        lim = ZR_AMI_ANSI;
        if (singleRail || code == LC_AMI) begin
            if (fcc && !e1) begin
                lim = ZR_AMI_FCC_T1;
            end
        end else if (code == LC_B8ZS) begin
            lim = ZR_B8ZS;
        end else begin
            lim = ZR_HDB3;
        end
        return lim;
    endfunction : lcv_zero_limit

endpackage : lcv_pkg

// ### lcv_rail_if.sv
// dual rail bit stream between the monitor modules.
// assumes bitEn is a one-cycle pulse per bit on the single system clock.
`timescale 1ns/10ps
interface lcv_rail_if;
    logic bitEn;
    logic pos;
    logic neg;
    modport sink (input bitEn, input pos, input neg);
    modport source (output bitEn, output pos, output neg);
endinterface : lcv_rail_if

// ### lcv_path_monitor.sv
// violation and zero-run detector for one direction of one channel.
// assumes pos/neg are valid with bitEn; pos alone carries single rail data.
`timescale 1ns/10ps
module lcv_path_monitor import lcv_pkg::*; #(
    parameter int ZERO_CNT_W = 7
) (
    // clock and reset
    input logic clk,
    input logic rst_n,
    // bit stream
    lcv_rail_if.sink rail,
    // configuration
    input lcv_code_t lineCode,
    input logic fccDef,
    input logic e1Mode,
    input logic singleRail,
    // events and state
    output logic violation,
    output logic zeroRun,
    output logic [ZERO_CNT_W-1:0] zeroCount
);
    if (ZERO_CNT_W < 7) begin : g_width_check
        $error("zero counter too narrow for the longest threshold");
    end

    logic [ZERO_CNT_W-1:0] zeroCnt_q, limit;
    logic lastPol_q, seenMark_q, lastVPol_q, seenV_q, secondV_q, fired_q;
    logic mark, pol, bpv, legit;

    always_comb begin
        mark = rail.pos | (rail.neg & ~singleRail);
        pol = rail.pos;
        limit = ZERO_CNT_W'(lcv_zero_limit(lineCode, fccDef, e1Mode,
            singleRail));
        bpv = mark & seenMark_q & (pol == lastPol_q) & ~singleRail;
        case (lineCode)
            LC_B8ZS: begin
                legit = (zeroCnt_q == ZERO_CNT_W'(B8ZS_FIRST_GAP)) |
                    (secondV_q & (zeroCnt_q == ZERO_CNT_W'(B8ZS_SECOND_GAP)));
            end
            LC_HDB3: begin
                legit = ((zeroCnt_q == ZERO_CNT_W'(HDB3_LONG_GAP)) |
                    (zeroCnt_q == ZERO_CNT_W'(HDB3_SHORT_GAP))) &
                    ~(seenV_q & (pol == lastVPol_q));
            end
            default: begin
                legit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zeroCnt_q <= '0;
        end else if (rail.bitEn) begin
            if (mark) begin
                zeroCnt_q <= '0;
            end else if (zeroCnt_q != '1) begin
                zeroCnt_q <= zeroCnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lastPol_q <= 1'b0;
            seenMark_q <= 1'b0;
            lastVPol_q <= 1'b0;
            seenV_q <= 1'b0;
            secondV_q <= 1'b0;
        end else if (rail.bitEn && mark) begin
            lastPol_q <= pol;
            seenMark_q <= 1'b1;
            if (bpv) begin
                lastVPol_q <= pol;
                seenV_q <= 1'b1;
                secondV_q <= (zeroCnt_q == ZERO_CNT_W'(B8ZS_FIRST_GAP));
            end else if (zeroCnt_q != '0) begin
                secondV_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            violation <= 1'b0;
            zeroRun <= 1'b0;
            fired_q <= 1'b0;
        end else begin
            violation <= rail.bitEn & bpv &
                ((lineCode == LC_AMI) | ~legit);
            zeroRun <= rail.bitEn & ~mark & ~fired_q &
                (zeroCnt_q == limit);
            if (rail.bitEn) begin
                fired_q <= mark ? 1'b0 : (fired_q | (zeroCnt_q == limit));
            end
        end
    end

    assign zeroCount = zeroCnt_q;

    a_zero_restart: assert property (@(posedge clk) disable iff (!rst_n)
        rail.bitEn && mark |=> zeroCnt_q == '0)
        else $error("zero counter did not restart on a mark");

endmodule : lcv_path_monitor

// ### lcv_violation_inserter.sv
// forces one same-polarity mark into the transmit stream on request.
// assumes bit strobes are at least two clocks apart.
`timescale 1ns/10ps
module lcv_violation_inserter (
    // clock and reset
    input logic clk,
    input logic rst_n,
    // streams
    lcv_rail_if.sink txIn,
    lcv_rail_if.source txOut,
    // request
    input logic insertReq,
    output logic insertDone
);
    logic outEn_q, outPos_q, outNeg_q, lastPol_q, done_q, mark, hit;

    assign mark = txIn.pos | txIn.neg;
    assign hit = txIn.bitEn & mark & insertReq & ~done_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outEn_q <= 1'b0;
            outPos_q <= 1'b0;
            outNeg_q <= 1'b0;
        end else begin
            outEn_q <= txIn.bitEn;
            if (txIn.bitEn) begin
                outPos_q <= hit ? lastPol_q : txIn.pos;
                outNeg_q <= hit ? ~lastPol_q : txIn.neg;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lastPol_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= hit;
            if (txIn.bitEn && mark && !hit) begin
                lastPol_q <= txIn.pos;
            end
        end
    end

    assign txOut.bitEn = outEn_q;
    assign txOut.pos = outPos_q;
    assign txOut.neg = outNeg_q;
    assign insertDone = done_q;

endmodule : lcv_violation_inserter

// ### lcv_monitor_top.sv
// line code violation monitor for one channel: registers, flags, pins.
// assumes classic wishbone on clk; rail bit strobes synchronous to clk.
// Function
// - report bipolar violations for AMI, code violations for B8ZS or HDB3.
// - monitor violations separately on receive and transmit paths.
// - single rail NRZ transmit input disables transmit violation detection.
// - two successive marks of equal polarity are a bipolar violation.
// - same-polarity violation pairs outside substitution patterns are code errors.
// - receive violation sets status bit 4, drives irq unless mask bit 4.
// - transmit violation sets status bit 5, drives irq unless mask bit 5.
// - violation insertion exists on the transmit path only.
// - writing one to fault control bit 6 forces a violation next mark.
// - insert request bit clears itself once the violation is sent.
// - zero-run detection runs on receive and transmit paths.
// - fault control bit 7 picks ANSI thresholds at 0, FCC at 1.
// - AMI fires above 15 zeros; FCC T1/J1 fires above 80.
// - B8ZS fires above 7 zeros under either definition.
// - HDB3 fires above 3 zeros under either definition.
// - single rail NRZ transmit zero-runs use AMI thresholds.
// - receive zero-run sets status bit 2, irq unless mask bit 2.
// - transmit zero-run sets status bit 3, irq unless mask bit 3.
// - violation events also go to error counter and indicator pins.
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module lcv_monitor_top import lcv_pkg::*; #(
    parameter int ZERO_CNT_W = 7
) (
    // clock and reset
    input logic clk,
    input logic rst_n,
    // wishbone slave
    input logic wb_cyc,
    input logic wb_stb,
    input logic wb_we,
    input logic [7:0] wb_adr,
    input logic [3:0] wb_sel,
    input logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // receive line stream
    input logic rxBitEn,
    input logic rxPos,
    input logic rxNeg,
    // transmit system stream
    input logic txBitEn,
    input logic txPos,
    input logic txNeg,
    // transmit stream towards the line
    output logic lineBitEn,
    output logic linePos,
    output logic lineNeg,
    // events and interrupt
    output logic irqN,
    output logic rxViolationEvent,
    output logic txViolationEvent,
    output logic rxZeroRunEvent,
    output logic txZeroRunEvent,
    output logic rx_multiplex_indicator,
    output logic tx_multiplex_indicator
);
    if (ZERO_CNT_W < 7 || ZERO_CNT_W > 16) begin : g_width_check
        $error("zero counter width must be 7 to 16");
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    lcv_code_t lineCode_q;
    logic e1Mode_q, singleRail_q;
    logic insertReq_q, zeroDef_q;
    logic [7:0] status_q, mask_q;
    logic ack_q, irqN_q;
    logic [31:0] rdData_q;
    logic busReq, wrEdge;
    logic wrCfg, wrFault, wrStatus, wrMask;
    logic rxViol, txViol, rxZero, txZero, insertDone;
    logic [ZERO_CNT_W-1:0] rxZeroCnt, txZeroCnt;
    logic [7:0] eventBits;
    logic [7:0] rxViolEv_q, txViolEv_q;

    lcv_rail_if rxRail ();
    lcv_rail_if txRail ();
    lcv_rail_if lineRail ();

    assign rxRail.bitEn = rxBitEn;
    assign rxRail.pos = rxPos;
    assign rxRail.neg = rxNeg;
    assign txRail.bitEn = txBitEn;
    assign txRail.pos = txPos;
    assign txRail.neg = txNeg;

    // ------------------------------------------------------------
    // path monitors and insertion
    // ------------------------------------------------------------
    // one monitor per path
    lcv_path_monitor #(
        .ZERO_CNT_W(ZERO_CNT_W)
    ) u_rx_monitor (
        .clk(clk),
        .rst_n(rst_n),
        .rail(rxRail),
        .lineCode(lineCode_q),
        .fccDef(zeroDef_q),
        .e1Mode(e1Mode_q),
        .singleRail(1'b0),
        .violation(rxViol),
        .zeroRun(rxZero),
        .zeroCount(rxZeroCnt)
    );

    // single rail applies to transmit only
    lcv_path_monitor #(
        .ZERO_CNT_W(ZERO_CNT_W)
    ) u_tx_monitor (
        .clk(clk),
        .rst_n(rst_n),
        .rail(txRail),
        .lineCode(lineCode_q),
        .fccDef(zeroDef_q),
        .e1Mode(e1Mode_q),
        .singleRail(singleRail_q),
        .violation(txViol),
        .zeroRun(txZero),
        .zeroCount(txZeroCnt)
    );

    // monitoring looks at the system input, so an inserted violation is
    // not reported against the system side
    lcv_violation_inserter u_inserter (
        .clk(clk),
        .rst_n(rst_n),
        .txIn(txRail),
        .txOut(lineRail),
        .insertReq(insertReq_q),
        .insertDone(insertDone)
    );

    assign lineBitEn = lineRail.bitEn;
    assign linePos = lineRail.pos;
    assign lineNeg = lineRail.neg;

    // ------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------
    // ack one cycle after the request; writes land on the ack edge
    assign busReq = wb_cyc & wb_stb;
    assign wrEdge = busReq & wb_we & ack_q & wb_sel[0];

    always_comb begin
        wrCfg = 1'b0;
        wrFault = 1'b0;
        wrStatus = 1'b0;
        wrMask = 1'b0;
        if (wb_adr == REG_LINE_CFG) begin
            wrCfg = wrEdge;
        end else if (wb_adr == REG_FAULT_CTRL) begin
            wrFault = wrEdge;
        end else if (wb_adr == REG_IRQ_STATUS_TWO) begin
            wrStatus = wrEdge;
        end else if (wb_adr == REG_IRQ_MASK_TWO) begin
            wrMask = wrEdge;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= busReq & ~ack_q;
        end
    end

    // unmapped addresses acknowledge and read as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q <= 32'h00000000;
        end else if (busReq && !ack_q) begin
            if (wb_adr == REG_LINE_CFG) begin
                rdData_q <= {28'h0000000, singleRail_q, e1Mode_q,
                    lineCode_q};
            end else if (wb_adr == REG_FAULT_CTRL) begin
                rdData_q <= {24'h000000, zeroDef_q, insertReq_q, 6'h00};
            end else if (wb_adr == REG_IRQ_STATUS_TWO) begin
                rdData_q <= {24'h000000, status_q & STATUS_USED};
            end else if (wb_adr == REG_IRQ_MASK_TWO) begin
                rdData_q <= {24'h000000, mask_q & STATUS_USED};
            end else if (wb_adr == REG_PATH_STATE) begin
                rdData_q <= {16'(txZeroCnt), 16'(rxZeroCnt)};
            end else begin
                rdData_q <= 32'h00000000;
            end
        end
    end

    assign wb_ack = ack_q;
    assign wb_dat_r = rdData_q;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lineCode_q <= LC_AMI;
            e1Mode_q <= CFG_RESET[CFG_E1_BIT];
            singleRail_q <= CFG_RESET[CFG_SINGLE_RAIL_BIT];
        end else if (wrCfg) begin
            // the spare code value falls back to AMI
            if (wb_dat_w[CFG_CODE_LSB +: 2] == 2'h3) begin
                lineCode_q <= LC_AMI;
            end else begin
                lineCode_q <= lcv_code_t'(wb_dat_w[CFG_CODE_LSB +: 2]);
            end
            e1Mode_q <= wb_dat_w[CFG_E1_BIT];
            singleRail_q <= wb_dat_w[CFG_SINGLE_RAIL_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zeroDef_q <= 1'b0;
        end else if (wrFault) begin
            zeroDef_q <= wb_dat_w[ZERO_DEF_BIT];
        end
    end

    // set by write, cleared by the inserter; a fresh write wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            insertReq_q <= 1'b0;
        end else if (wrFault && wb_dat_w[INSERT_REQ_BIT]) begin
            insertReq_q <= 1'b1;
        end else if (insertDone) begin
            insertReq_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= MASK_RESET;
        end else if (wrMask) begin
            mask_q <= wb_dat_w[7:0] & STATUS_USED;
        end
    end

    // ------------------------------------------------------------
    // status flags and interrupt pin
    // ------------------------------------------------------------
    always_comb begin
        eventBits = 8'h00;
        eventBits[LINE_ZERO_RUN_BIT] = rxZero;
        eventBits[SYS_ZERO_RUN_BIT] = txZero;
        eventBits[LINE_VIOLATION_BIT] = rxViol;
        eventBits[SYS_VIOLATION_BIT] = txViol;
    end

    // sticky, write one clears, a new event wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q <= (status_q & ~(wrStatus ? wb_dat_w[7:0] : 8'h00)) |
                eventBits;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqN_q <= 1'b1;
        end else begin
            irqN_q <= ~|(status_q & ~mask_q & STATUS_USED);
        end
    end

    assign irqN = irqN_q;

    // ------------------------------------------------------------
    // event sources for the error counter and indicator pins
    // ------------------------------------------------------------
    // violation and zero-run events exported
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxViolEv_q <= 8'h00;
            txViolEv_q <= 8'h00;
        end else begin
            rxViolEv_q <= {6'h00, rxZero, rxViol};
            txViolEv_q <= {6'h00, txZero, txViol};
        end
    end

    assign rxViolationEvent = rxViolEv_q[0];
    assign txViolationEvent = txViolEv_q[0];
    assign rxZeroRunEvent = rxViolEv_q[1];
    assign txZeroRunEvent = txViolEv_q[1];
    assign rx_multiplex_indicator = rxViolEv_q[0];
    assign tx_multiplex_indicator = txViolEv_q[0];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence sInsertWrite;
        wrFault && wb_dat_w[INSERT_REQ_BIT];
    endsequence

    sequence sInsertDoneNoWrite;
        insertDone && !(wrFault && wb_dat_w[INSERT_REQ_BIT]);
    endsequence

    a_line_viol_flag: assert property (rxViol |=> status_q[4] &&
        rxViolationEvent && rx_multiplex_indicator)
        else $error("receive violation did not set flag and pin");

    a_sys_viol_flag: assert property (txViol |=>
        status_q[5] && txViolationEvent && tx_multiplex_indicator)
        else $error("transmit violation did not set flag and pin");

    a_line_zero_flag: assert property (rxZero |=> status_q[2])
        else $error("receive zero run did not set its flag");

    a_sys_zero_flag: assert property (txZero |=> status_q[3])
        else $error("transmit zero run did not set its flag");

    a_flag_sticky: assert property (status_q[4] && !(wrStatus &&
        wb_dat_w[LINE_VIOLATION_BIT]) |=> status_q[4])
        else $error("line violation flag dropped without a clear");

    a_irq_unmasked: assert property (status_q[5] && !mask_q[5]
        |=> !irqN ##1 (!irqN || !status_q[5] || mask_q[5]))
        else $error("unmasked system violation left irq high");

    a_irq_masked: assert property (((status_q & ~mask_q & STATUS_USED)
        == 8'h00) |=> irqN)
        else $error("irq low with no unmasked flag");

    a_nrz_tx_quiet: assert property (singleRail_q && $past(singleRail_q)
        |-> !txViol)
        else $error("transmit violation reported in single rail mode");

    a_insert_set: assert property (sInsertWrite |=> insertReq_q)
        else $error("insert request not taken");

    a_insert_clear: assert property (sInsertDoneNoWrite
        |=> !insertReq_q)
        else $error("insert request did not clear itself");

    a_insert_hold: assert property (insertReq_q && !insertDone
        |=> insertReq_q)
        else $error("pending insert request lost");

    a_insert_polarity: assert property (insertDone |-> lineBitEn &&
        (linePos != lineNeg))
        else $error("inserted mark is not a single polarity mark");

    a_ack_single: assert property (wb_ack |=> !wb_ack)
        else $error("ack held longer than one cycle");

endmodule : lcv_monitor_top

// ### lcv_rail_src.sv
// bit source model for the line receiver or the system framer side.
// assumes callers enter send right after a rising clock edge.
`timescale 1ns/10ps
module lcv_rail_src (
    // clock
    input logic clk,
    // bit stream
    output logic bitEn = 1'b0,
    output logic pos = 1'b0,
    output logic neg = 1'b0
);
    // marks on demand
    // idle rails flip so a stale mark is never taken as a fresh one
    task automatic send(input logic m, input logic p);
        bitEn <= 1'b1;
        pos <= m & p;
        neg <= m & ~p;
        @(posedge clk);
        bitEn <= 1'b0;
        pos <= ~(m & p);
        neg <= ~(m & ~p);
        repeat (3) @(posedge clk);
    endtask : send
endmodule : lcv_rail_src

// ### test_line_code_violation_monitor.sv
// self-checking bench for the line code violation monitor.
// assumes the rail source model and a one-cycle wishbone answer.
`timescale 1ns/10ps
module test_line_code_violation_monitor;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, irqN;
    logic [7:0] wb_adr = 8'h00, wbDat = 8'h00, q;
    logic [31:0] wb_dat_r;
    logic lineBitEn, linePos, lineNeg, rxEn, rxP, rxN, txEn, txP, txN;
    logic [1:0] lastLine = 2'b00;
    logic rxVe, txVe, rxZe, txZe, rxMi, txMi;
    logic [7:0] rxVc = 8'h00, txVc = 8'h00, zrc = 8'h00;
    int miscompares = 0, checks_done = 0;
    always #2.5 clk = ~clk;
    lcv_monitor_top lcv_monitor_top_i (.clk(clk), .rst_n(rst_n),
        .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
        .wb_sel(4'hF), .wb_dat_w({24'h000000, wbDat}), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .rxBitEn(rxEn), .rxPos(rxP), .rxNeg(rxN),
        .txBitEn(txEn), .txPos(txP), .txNeg(txN), .lineBitEn(lineBitEn),
        .linePos(linePos), .lineNeg(lineNeg), .irqN(irqN),
        .rxViolationEvent(rxVe), .txViolationEvent(txVe),
        .rxZeroRunEvent(rxZe), .txZeroRunEvent(txZe),
        .rx_multiplex_indicator(rxMi), .tx_multiplex_indicator(txMi));
    lcv_rail_src rx_src_i (.clk(clk), .bitEn(rxEn), .pos(rxP), .neg(rxN));
    lcv_rail_src tx_src_i (.clk(clk), .bitEn(txEn), .pos(txP), .neg(txN));
    // only marks are kept, to see the polarity of the forced one
    always @(posedge clk)
        if (lineBitEn && (linePos || lineNeg))
            lastLine <= {linePos, lineNeg};
    // counted only out of reset; a violation shows on its event output
    // and on its indicator pin, so each one counts twice
    always @(posedge clk)
        if (rst_n) begin
            rxVc <= rxVc + 8'(rxVe) + 8'(rxMi);
            txVc <= txVc + 8'(txVe) + 8'(txMi);
            zrc <= zrc + 8'(rxZe) + 8'(txZe);
        end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wbDat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 40);
        q = wb_dat_r[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (wb_ack !== 1'b1) begin
            miscompares++;
            end_sim;
        end
        @(posedge clk);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [7:0] m,
        input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(q & m, e);
    endtask : rd
    task automatic snd(input logic tx, input logic m, input logic p);
        if (tx) begin
            tx_src_i.send(m, p);
        end else begin
            rx_src_i.send(m, p);
        end
    endtask : snd
    // a run of exactly the limit in zeros stays quiet, the next zero fires
    task automatic zc(input logic [7:0] cfg, input logic [7:0] flt,
        input logic tx, input int n, input logic [7:0] b);
        wb(1'b1, 8'h00, cfg);
        wb(1'b1, 8'h04, flt);
        wb(1'b1, 8'h08, 8'h3C);
        snd(tx, 1'b1, 1'b1);
        repeat (n) snd(tx, 1'b0, 1'b0);
        rd(8'h08, b, 8'h00);
        snd(tx, 1'b0, 1'b0);
        rd(8'h08, b, b);
    endtask : zc
    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(8'h0C, 8'hFF, 8'h3C);
        rd(8'h08, 8'hFF, 8'h00);
        rd(8'h20, 8'hFF, 8'h00);
        wb(1'b1, 8'h0C, 8'h00);
        repeat (2) snd(1'b0, 1'b1, 1'b1);
        rd(8'h08, 8'hFF, 8'h10);
        chk({7'h00, irqN}, 8'h00);
        wb(1'b1, 8'h08, 8'h10);
        rd(8'h08, 8'hFF, 8'h00);
        chk({7'h00, irqN}, 8'h01);
        wb(1'b1, 8'h0C, 8'h3C);
        repeat (2) snd(1'b1, 1'b1, 1'b1);
        rd(8'h08, 8'hFF, 8'h20);
        chk({7'h00, irqN}, 8'h01);
        wb(1'b1, 8'h0C, 8'h1C);
        rd(8'h0C, 8'hFF, 8'h1C);
        chk({7'h00, irqN}, 8'h00);
        wb(1'b1, 8'h08, 8'h20);
        wb(1'b1, 8'h00, 8'h08);
        repeat (2) snd(1'b1, 1'b1, 1'b1);
        rd(8'h08, 8'h20, 8'h00);
        zc(8'h00, 8'h00, 1'b0, 15, 8'h04);
        rd(8'h10, 8'hFF, 8'h10);
        zc(8'h02, 8'h00, 1'b1, 3, 8'h08);
        zc(8'h01, 8'h80, 1'b0, 7, 8'h04);
        zc(8'h00, 8'h80, 1'b1, 80, 8'h08);
        zc(8'h04, 8'h80, 1'b0, 15, 8'h04);
        zc(8'h09, 8'h00, 1'b1, 15, 8'h08);
        wb(1'b1, 8'h00, 8'h00);
        snd(1'b1, 1'b1, 1'b1);
        wb(1'b1, 8'h04, 8'h40);
        repeat (2) snd(1'b1, 1'b0, 1'b0);
        snd(1'b1, 1'b1, 1'b0);
        chk({6'h00, lastLine}, 8'h02);
        rd(8'h04, 8'h40, 8'h00);
        chk(rxVc, 8'h08);
        chk(txVc, 8'h08);
        chk(zrc, 8'h06);
        end_sim;
    end
endmodule : test_line_code_violation_monitor
